// ### design/cpmc_pkg.sv
// shared constants, types and decoders for the core pll configuration block
package cpmc_pkg;

	// configuration register field layout
	localparam int          CFG_W            = 8;
	localparam int          RANGE_BIT        = 7;
	localparam int          DIVIDEND_MSB     = 6;
	localparam int          DIVIDEND_LSB     = 2;
	localparam int          DIVISOR_MSB      = 1;
	localparam int          DIVISOR_LSB      = 0;

	// decoded widths and the special zero codes
	localparam int          DIVIDEND_W       = 6;
	localparam int          DIVISOR_W        = 3;
	localparam logic [5:0]  DIVIDEND_ZERO    = 6'h20;
	localparam logic [2:0]  DIVISOR_ZERO     = 3'h5;

	// value after reset: range set, 15/2, 150 MHz from a 20 MHz reference
	localparam logic [7:0]  CFG_RESET        = 8'hBE;

	// frequency figures in kHz
	localparam int          DEFAULT_REF_KHZ  = 20000;
	localparam int          CORE_TARGET_KHZ  = 150000;
	localparam int          REF_LIMIT_KHZ    = 167000;
	localparam int          REF_LIMIT_MULT   = 4;

	// serial bit period in core cycles: 150 MHz / 115,200 baud
	localparam int          BAUD_DIV_W       = 16;
	localparam logic [15:0] BAUD_DIV_RESET   = 16'h0516;

	// register field view
	typedef struct packed {
		logic       range_sel;
		logic [4:0] dividend_code;
		logic [1:0] divisor_code;
	} cpmc_cfg_s;

	// startup sequence
	typedef enum logic [1:0] {
		ST_RESET  = 2'b00,
		ST_SCRIPT = 2'b01,
		ST_RUN    = 2'b10
	} cpmc_state_e;

	function automatic logic [5:0] decode_dividend(input logic [4:0] code);
		decode_dividend = (code == 5'h00) ? DIVIDEND_ZERO : {1'b0, code};
	endfunction : decode_dividend

	function automatic logic [2:0] decode_divisor(input logic [1:0] code);
		decode_divisor = (code == 2'h0) ? DIVISOR_ZERO : {1'b0, code};
	endfunction : decode_divisor

endpackage : cpmc_pkg

// ### design/cpmc_baud_tick.sv
// serial bit tick paced by core clock credit from the pll ratio
`timescale 1ns/1ps
module cpmc_baud_tick
	import cpmc_pkg::*;
#(
	parameter int BDW = BAUD_DIV_W
) (
	// clock and reset
	input  wire logic           ref_clk_i,
	input  wire logic           rst_n_i,
	// reference edge and ratio
	input  wire logic           ref_edge_i,
	input  wire logic [5:0]     dividend_i,
	input  wire logic [2:0]     divisor_i,
	input  wire logic [BDW-1:0] baud_div_i,
	// bit tick
	output logic                tick_o
);

	localparam int AW = BDW + 4;

	logic [AW-1:0] acc_r;
	logic [AW-1:0] thr;
	logic [AW-1:0] sum;

	// each reference edge is worth dividend/divisor core cycles; scaling
	// by divisor keeps it integer, so no rounding drift accumulates
	assign thr = AW'(divisor_i) * AW'(baud_div_i);
	assign sum = acc_r + AW'(dividend_i);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_r  <= '0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (ref_edge_i) begin
				if (sum >= thr) begin
					acc_r  <= sum - thr;
					tick_o <= 1'b1;
				end else begin
					acc_r <= sum;
				end
			end
		end
	end

endmodule : cpmc_baud_tick

// ### design/cpmc_pll_config.sv
// core pll multiplier configuration register with startup script load
`timescale 1ns/1ps
module cpmc_pll_config
	import cpmc_pkg::*;
(
	// clock and reset
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_n_i,
	// external reference oscillator, sampled
	input  wire logic                  external_reference_input_i,
	input  wire logic [17:0]           ref_freq_khz_i,
	// startup script entry
	input  wire logic                  script_valid_i,
	input  wire logic [CFG_W-1:0]      script_cfg_i,
	// register write and read port
	input  wire logic                  cfg_wr_i,
	input  wire logic [CFG_W-1:0]      cfg_wdata_i,
	output logic [CFG_W-1:0]           cfg_rdata_o,
	// serial bit period in core cycles
	input  wire logic [BAUD_DIV_W-1:0] baud_div_i,
	// decoded pll setting and status
	output logic                       pll_range_select_o,
	output logic [DIVIDEND_W-1:0]      dividend_o,
	output logic [DIVISOR_W-1:0]       multiplier_divisor_o,
	output logic                       cfg_ready_o,
	output logic                       core_freq_ok_o,
	output logic                       ref_freq_ok_o,
	output logic                       baud_tick_o
);

	cpmc_state_e state_r;
	cpmc_state_e state_nxt;

	cpmc_cfg_s core_pll_multiplier_config_r;
	logic      ref_prev_r;
	logic      ref_edge;
	logic      sw_wr_ok;

	logic [5:0]  dividend;
	logic [2:0]  divisor;
	logic [35:0] core_lhs;
	logic [35:0] core_rhs;
	logic [35:0] ref_lhs;

	// run state test, shared by write gating and the ready output
	function automatic logic in_run(input cpmc_state_e st);
		in_run = (st == ST_RUN);
	endfunction : in_run

	// script window test; only one cycle wide after reset release
	function automatic logic in_script(input cpmc_state_e st);
		in_script = (st == ST_SCRIPT);
	endfunction : in_script

	// startup ordering
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			// one idle edge so the reset value is visible first
			ST_RESET: begin
				state_nxt = ST_SCRIPT;
			end
			// script entry gets exactly one edge
			ST_SCRIPT: begin
				state_nxt = ST_RUN;
			end
			// stays here until the next reset
			ST_RUN: begin
				state_nxt = ST_RUN;
			end
			// unused code, recover through the startup path
			default: begin
				state_nxt = ST_RESET;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// writes before the script has run would be overwritten, so hold off
	assign sw_wr_ok = in_run(state_r) && cfg_wr_i;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core_pll_multiplier_config_r <= cpmc_cfg_s'(CFG_RESET);
		end else if (in_script(state_r) && script_valid_i) begin
			core_pll_multiplier_config_r <= cpmc_cfg_s'(script_cfg_i);
		end else if (sw_wr_ok) begin
			core_pll_multiplier_config_r <= cpmc_cfg_s'(cfg_wdata_i);
		end
	end

	assign dividend =
		decode_dividend(core_pll_multiplier_config_r.dividend_code);
	assign divisor =
		decode_divisor(core_pll_multiplier_config_r.divisor_code);

	assign core_lhs = 36'(ref_freq_khz_i) * 36'(dividend);
	assign core_rhs = 36'(CORE_TARGET_KHZ) * 36'(divisor);
	assign ref_lhs  = 36'(ref_freq_khz_i) * 36'(REF_LIMIT_MULT);

	// register copy, one cycle behind the store
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_rdata_o        <= CFG_RESET;
			pll_range_select_o <= CFG_RESET[RANGE_BIT];
		end else begin
			cfg_rdata_o        <= core_pll_multiplier_config_r;
			pll_range_select_o <= core_pll_multiplier_config_r.range_sel;
		end
	end

	// decoded ratio; zero in reset so no stale ratio is shown
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dividend_o           <= '0;
			multiplier_divisor_o <= '0;
		end else begin
			dividend_o           <= dividend;
			multiplier_divisor_o <= divisor;
		end
	end

	// ready lags the run state by one edge, writes count one earlier
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_ready_o <= 1'b0;
		end else begin
			cfg_ready_o <= in_run(state_r);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core_freq_ok_o <= 1'b0;
		end else begin
			// exact match only; a near miss still upsets the serial rate
			core_freq_ok_o <= (core_lhs == core_rhs);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_freq_ok_o <= 1'b0;
		end else begin
			// limit is inclusive, equality still passes
			ref_freq_ok_o <= (ref_lhs <= 36'(REF_LIMIT_KHZ));
		end
	end

	// reference edge, pin taken as synchronous
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_prev_r <= 1'b0;
		end else begin
			ref_prev_r <= external_reference_input_i;
		end
	end

	// prev resets to the idle low level, so no false edge after reset;
	// edges closer than two clocks merge, a limit on the reference rate
	assign ref_edge = external_reference_input_i & ~ref_prev_r;

	cpmc_baud_tick #(
		.BDW        (BAUD_DIV_W)
	) u_baud (
		.ref_clk_i  (ref_clk_i),
		.rst_n_i    (rst_n_i),
		.ref_edge_i (ref_edge),
		.dividend_i (dividend),
		.divisor_i  (divisor),
		.baud_div_i (baud_div_i),
		.tick_o     (baud_tick_o)
	);

endmodule : cpmc_pll_config

// ### bench/cpmc_osc_model.sv
// reference oscillator model with a settable half period
`timescale 1ns/1ps
module cpmc_osc_model (
	// clock in, half period in clock cycles
	input  wire logic       ref_clk_i,
	input  wire logic [7:0] half_i,
	// oscillator pin
	output logic            osc_o
);
	logic [7:0] cnt_r = 8'h00;
	initial osc_o = 1'b0;
	always @(negedge ref_clk_i) begin
		cnt_r <= (cnt_r + 8'h01 >= half_i) ? 8'h00 : cnt_r + 8'h01;
		if (cnt_r + 8'h01 >= half_i)
			osc_o <= ~osc_o;
	end
endmodule : cpmc_osc_model

// ### bench/cpmc_pll_config_checker.sv
// concurrent checks on the pll configuration ports
`timescale 1ns/1ps
module cpmc_pll_config_checker (
	// grouped to keep the file short
	input wire logic ref_clk_i, rst_n_i, script_valid_i, cfg_wr_i,
	input wire logic pll_range_select_o, cfg_ready_o, baud_tick_o,
	input wire logic core_freq_ok_o, ref_freq_ok_o,
	input wire logic [17:0] ref_freq_khz_i,
	input wire logic [7:0] script_cfg_i, cfg_wdata_i, cfg_rdata_o,
	input wire logic [5:0] dividend_o,
	input wire logic [2:0] multiplier_divisor_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	range_bit_a: assert property (cfg_ready_o |->
		pll_range_select_o == cfg_rdata_o[7]) else $error("range bit");
	dividend_dec_a: assert property (cfg_ready_o |-> dividend_o ==
		(cfg_rdata_o[6:2] == 5'h00 ? 6'h20 : {1'b0, cfg_rdata_o[6:2]}))
		else $error("dividend decode");
	divisor_dec_a: assert property (cfg_ready_o |->
		multiplier_divisor_o ==
		(cfg_rdata_o[1:0] == 2'h0 ? 3'h5 : {1'b0, cfg_rdata_o[1:0]}))
		else $error("divisor decode");
	write_lat_a: assert property (cfg_ready_o && cfg_wr_i ##1 !cfg_wr_i
		|=> cfg_rdata_o == $past(cfg_wdata_i, 2)) else $error("write lost");
	script_load_a: assert property ($rose(cfg_ready_o) &&
		$past(script_valid_i, 2) |-> cfg_rdata_o == $past(script_cfg_i, 2))
		else $error("script not applied");
	core_ratio_a: assert property (cfg_ready_o && $past(cfg_ready_o) |->
		core_freq_ok_o == ($past(ref_freq_khz_i) * dividend_o ==
		150000 * multiplier_divisor_o)) else $error("core flag");
	ref_limit_a: assert property (cfg_ready_o |-> ref_freq_ok_o ==
		($past(ref_freq_khz_i) * 4 <= 167000)) else $error("ref flag");
	tick_pulse_a: assert property (baud_tick_o |=> !baud_tick_o)
		else $error("tick too long");
endmodule : cpmc_pll_config_checker
bind cpmc_pll_config cpmc_pll_config_checker chk_u (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i),
	.script_valid_i(script_valid_i), .script_cfg_i(script_cfg_i),
	.pll_range_select_o(pll_range_select_o), .cfg_ready_o(cfg_ready_o),
	.baud_tick_o(baud_tick_o), .core_freq_ok_o(core_freq_ok_o),
	.ref_freq_ok_o(ref_freq_ok_o), .ref_freq_khz_i(ref_freq_khz_i),
	.cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
	.dividend_o(dividend_o), .multiplier_divisor_o(multiplier_divisor_o));

// ### bench/tb_core_pll_multiplier_config.sv
// self-checking bench for the core pll configuration block
`timescale 1ns/1ps
module tb_core_pll_multiplier_config;
	logic        clk = 0, rst_n = 0, osc, sv = 0, wr = 0, rng, rdy, cok, rok, tk;
	logic [7:0]  scfg = 0, wd = 0, rd, half = 2, d;
	logic [17:0] khz = 20000;
	logic [15:0] bdiv = 15;
	logic [5:0]  dvd;
	logic [2:0]  dvs;
	int          mismatches = 0, n_tests = 0, cyc = 0, c, i;
	initial forever #2.5 clk = ~clk;
	cpmc_osc_model osc_u (.ref_clk_i(clk), .half_i(half), .osc_o(osc));
	cpmc_pll_config dut_u (.ref_clk_i(clk), .rst_n_i(rst_n),
		.external_reference_input_i(osc), .ref_freq_khz_i(khz),
		.script_valid_i(sv), .script_cfg_i(scfg), .cfg_wr_i(wr),
		.cfg_wdata_i(wd), .cfg_rdata_o(rd), .baud_div_i(bdiv),
		.pll_range_select_o(rng), .dividend_o(dvd),
		.multiplier_divisor_o(dvs), .cfg_ready_o(rdy),
		.core_freq_ok_o(cok), .ref_freq_ok_o(rok), .baud_tick_o(tk));
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	task automatic cfg_chk(logic [7:0] v);
		check("rdata", rd, v);
		check("range", rng, v[7]);
		check("dividend", dvd, v[6:2] == 0 ? 6'h20 : v[6:2]);
		check("divisor", dvs, v[1:0] == 0 ? 3'h5 : v[1:0]);
	endtask : cfg_chk
	task automatic reset_dut(logic s, logic [7:0] v);
		rst_n = 0;
		sv = s;
		scfg = v;
		repeat (5) @(negedge clk);
		check("reset rdata", rd, 8'hBE);
		rst_n = 1;
		repeat (4) @(negedge clk);
		check("ready", rdy, 1'b1);
	endtask : reset_dut
	task automatic set_cfg(logic [7:0] v);
		wr = 1;
		wd = v;
		@(negedge clk);
		wr = 0;
		repeat (2) @(negedge clk);
		cfg_chk(v);
	endtask : set_cfg
	// settle first so the accumulator forgets the old rate
	task automatic ticks(logic [7:0] h, int e);
		half = h;
		c = 0;
		repeat (40) @(negedge clk);
		repeat (1200) begin
			@(negedge clk);
			c += tk;
		end
		check("ticks", c >= e - 1 && c <= e + 1, 1'b1);
	endtask : ticks
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		void'($urandom(78865));
		reset_dut(0, 8'h00);
		cfg_chk(8'hBE);
		check("core ok", cok, 1'b1);
		ticks(2, 150);
		ticks(4, 75);
		khz = 10000;
		repeat (2) @(negedge clk);
		check("core ok 10", cok, 1'b0);
		set_cfg(8'hBD);
		check("core ok fixed", cok, 1'b1);
		ticks(4, 150);
		for (i = 0; i < 2; i++) begin
			khz = 41750 + i;
			repeat (2) @(negedge clk);
			check("ref ok", rok, i == 0);
		end
		for (i = 0; i < 24; i++) begin
			d = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom);
			set_cfg(d);
		end
		// back to back, the last write wins
		wr = 1;
		wd = 8'h11;
		@(negedge clk);
		set_cfg(8'h84);
		reset_dut(1, 8'hBD);
		cfg_chk(8'hBD);
		stop_test();
	end
endmodule : tb_core_pll_multiplier_config
